/* fdac_pkg.sv */
// Package: addresses, field positions and reset values for the diskette adapter control block
package fdac_pkg;

  localparam logic [9:0] FDAC_ADDR_DRIVE_CONTROL = 10'h03f2;
  localparam logic [9:0] FDAC_ADDR_MAIN_STATUS   = 10'h03f4;
  localparam logic [9:0] FDAC_ADDR_DATA_PORT     = 10'h03f5;

  localparam int unsigned FDAC_BIT_SEL0   = 0;
  localparam int unsigned FDAC_BIT_SEL1   = 1;
  localparam int unsigned FDAC_BIT_RUN    = 2;
  localparam int unsigned FDAC_BIT_REQEN  = 3;
  localparam int unsigned FDAC_BIT_MOTOR0 = 4;
  localparam int unsigned FDAC_BIT_MOTOR1 = 5;

  localparam logic [5:0] FDAC_DRIVE_CONTROL_RST = 6'h00;
  localparam logic [7:0] FDAC_BYTE_RST          = 8'h00;

  // Host I/O bus cycle as seen by the block
  typedef struct packed {
    logic [9:0] addr;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
  } fdac_io_req_t;

  // Per-drive cable outputs
  typedef struct packed {
    logic select;
    logic motor;
  } fdac_drive_t;

endpackage : fdac_pkg

/* fdac_top.sv */
// Diskette adapter control: drive control register, core port decode and request gating
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module fdac_top
  import fdac_pkg::*;
(
  // Clock, reset, enable
  input  wire  logic                clk,
  input  wire  logic                rstn,
  input  wire  logic                clk_en,
  // Host I/O bus, same clock domain
  input  wire  fdac_pkg::fdac_io_req_t io_req,
  output logic [7:0]                io_rdata,
  output logic                      io_rdata_oe,
  // Controller core register access
  input  wire  logic [7:0]          core_status,
  input  wire  logic [7:0]          core_data_rd,
  output logic                      core_data_rd_stb,
  output logic                      core_data_wr_stb,
  output logic [7:0]                core_data_wdata,
  output logic                      core_run_n_hold,
  // Controller core requests, gated onto the bus
  input  wire  logic                core_irq,
  input  wire  logic                core_drq,
  output logic                      bus_irq,
  output logic                      bus_irq_oe,
  output logic                      bus_drq,
  output logic                      bus_drq_oe,
  // Drive cable
  output fdac_pkg::fdac_drive_t     first_drive,
  output fdac_pkg::fdac_drive_t     second_drive
);
  import fdac_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode

  function automatic logic hit(input logic [9:0] a, input logic [9:0] ref_addr);
    hit = (a == ref_addr);
  endfunction : hit

  // Select decode shared by both drive outputs: a code picks a drive only with its motor on
  function automatic logic pick(input logic [5:0] dc, input int unsigned motor_bit,
                                input logic [1:0] code);
    logic [1:0] sel;
    sel  = {dc[FDAC_BIT_SEL1], dc[FDAC_BIT_SEL0]};
    pick = dc[motor_bit] && (sel == code);
  endfunction : pick

  logic rd_status;
  logic rd_data;
  logic wr_data;
  logic wr_ctrl;
  logic rd_ctrl;

  // Full ten-bit match, so no alias of the three ports answers elsewhere in the I/O map
  assign rd_status = io_req.rd && hit(io_req.addr, FDAC_ADDR_MAIN_STATUS);
  assign rd_data   = io_req.rd && hit(io_req.addr, FDAC_ADDR_DATA_PORT);
  assign wr_data   = io_req.wr && hit(io_req.addr, FDAC_ADDR_DATA_PORT);
  assign wr_ctrl   = io_req.wr && hit(io_req.addr, FDAC_ADDR_DRIVE_CONTROL);
  assign rd_ctrl   = io_req.rd && hit(io_req.addr, FDAC_ADDR_DRIVE_CONTROL);

  ////////////////////////////////////////////////////////////////////////////////
  // Drive control register, only bits 5:0 are stored

  logic [5:0] drive_control_ff;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      drive_control_ff <= FDAC_DRIVE_CONTROL_RST;
    end else if (clk_en && wr_ctrl) begin
      drive_control_ff <= io_req.wdata[5:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next output values

  logic       nxt_sel_first;
  logic       nxt_sel_second;
  logic       nxt_run;
  logic       nxt_reqen;
  logic       nxt_irq;
  logic       nxt_drq;
  logic [5:0] nxt_dc;
  logic [7:0] nxt_rdata;

  // Use the value being written so outputs follow the register with one flop of delay only
  assign nxt_dc = (clk_en && wr_ctrl) ? io_req.wdata[5:0] : drive_control_ff;

  // Codes 10 and 11 select no drive
  assign nxt_sel_first  = pick(nxt_dc, FDAC_BIT_MOTOR0, 2'h0);
  assign nxt_sel_second = pick(nxt_dc, FDAC_BIT_MOTOR1, 2'h1);

  assign nxt_run   = nxt_dc[FDAC_BIT_RUN];
  assign nxt_reqen = nxt_dc[FDAC_BIT_REQEN];
  assign nxt_irq   = nxt_reqen && core_irq;
  assign nxt_drq   = nxt_reqen && core_drq;

  // Read data is zero when nothing is read, so a stale byte never rides the bus
  always_comb begin
    nxt_rdata = FDAC_BYTE_RST;
    if (rd_status) begin
      nxt_rdata = core_status;
    end else if (rd_data) begin
      nxt_rdata = core_data_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Drive cable outputs

  // A drive is never selected without its motor, so a stray code cannot step a stopped drive
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      first_drive  <= '0;
      second_drive <= '0;
    end else if (clk_en) begin
      first_drive.motor   <= nxt_dc[FDAC_BIT_MOTOR0];
      second_drive.motor  <= nxt_dc[FDAC_BIT_MOTOR1];
      first_drive.select  <= nxt_sel_first;
      second_drive.select <= nxt_sel_second;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Controller core reset hold

  // Low from reset, so the core stays stopped until software sets the run bit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      core_run_n_hold <= 1'b0;
    end else if (clk_en) begin
      core_run_n_hold <= nxt_run;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt request gating

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_irq    <= 1'b0;
      bus_irq_oe <= 1'b0;
    end else if (clk_en) begin
      bus_irq_oe <= nxt_reqen;
      bus_irq    <= nxt_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // DMA request gating

  // The level drops with the driver enable, so a re-enabled driver never shows an old request
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_drq    <= 1'b0;
      bus_drq_oe <= 1'b0;
    end else if (clk_en) begin
      bus_drq_oe <= nxt_reqen;
      bus_drq    <= nxt_drq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Core data port strobes

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      core_data_rd_stb <= 1'b0;
      core_data_wr_stb <= 1'b0;
    end else if (clk_en) begin
      core_data_rd_stb <= rd_data;
      core_data_wr_stb <= wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Core data port write byte

  // Holds the last byte written so the core may take it after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      core_data_wdata <= FDAC_BYTE_RST;
    end else if (clk_en && wr_data) begin
      core_data_wdata <= io_req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Host read enable

  // Reads of the control address leave the bus undriven
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      io_rdata_oe <= 1'b0;
    end else if (clk_en) begin
      io_rdata_oe <= (rd_status || rd_data) && !rd_ctrl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Host read data byte

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      io_rdata <= FDAC_BYTE_RST;
    end else if (clk_en) begin
      io_rdata <= nxt_rdata;
    end
  end

endmodule : fdac_top

/* fdac_chk.sv */
// Port assertions for the diskette adapter control block
`timescale 1ns/10ps
module fdac_chk
  import fdac_pkg::*;
(
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   rstn,
  // Host side
  input wire logic                   clk_en,
  input wire fdac_pkg::fdac_io_req_t io_req,
  input wire logic [7:0]             io_rdata,
  input wire logic                   io_rdata_oe,
  input wire logic [7:0]             core_status,
  // Control outputs
  input wire logic                   core_run_n_hold,
  input wire logic                   bus_irq,
  input wire logic                   bus_irq_oe,
  input wire fdac_pkg::fdac_drive_t  first_drive,
  input wire fdac_pkg::fdac_drive_t  second_drive
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_wr;
    clk_en && io_req.wr && io_req.addr == FDAC_ADDR_DRIVE_CONTROL;
  endsequence
  sequence s_rd(a);
    clk_en && io_req.rd && io_req.addr == a;
  endsequence
  AST_MOTOR0: assert property (s_wr |=> first_drive.motor == $past(io_req.wdata[4]))
    else $error("first motor wrong");
  AST_MOTOR1: assert property (s_wr |=> second_drive.motor == $past(io_req.wdata[5]))
    else $error("second motor wrong");
  AST_RUN: assert property (s_wr |=> core_run_n_hold == $past(io_req.wdata[2]))
    else $error("core hold wrong");
  AST_GATE_OE: assert property (s_wr |=> bus_irq_oe == $past(io_req.wdata[3]))
    else $error("request gate wrong");
  AST_GATE_IRQ: assert property (!bus_irq_oe |-> !bus_irq)
    else $error("request passed while gated");
  AST_SEL: assert property (first_drive.select |-> first_drive.motor)
    else $error("select without motor");
  AST_STATUS: assert property (s_rd(FDAC_ADDR_MAIN_STATUS) |=>
    io_rdata_oe && io_rdata == $past(core_status)) else $error("status read wrong");
  AST_CTL_RD: assert property (s_rd(FDAC_ADDR_DRIVE_CONTROL) |=> !io_rdata_oe)
    else $error("control register readable");
  AST_RESET: assert property ($rose(rstn) |-> !core_run_n_hold && !bus_irq_oe)
    else $error("reset state wrong");
endmodule : fdac_chk
bind fdac_top fdac_chk i_fdac_chk (
  .clk(clk), .rstn(rstn), .clk_en(clk_en), .io_req(io_req), .io_rdata(io_rdata),
  .io_rdata_oe(io_rdata_oe), .core_status(core_status), .core_run_n_hold(core_run_n_hold),
  .bus_irq(bus_irq), .bus_irq_oe(bus_irq_oe), .first_drive(first_drive),
  .second_drive(second_drive)
);

/* fdac_host.sv */
// Host processor model issuing single I/O bus cycles
`timescale 1ns/10ps
module fdac_host
  import fdac_pkg::*;
(
  // Bus clock
  input  wire logic              clk,
  // Requests towards the block
  output fdac_pkg::fdac_io_req_t io_req
);
  initial io_req = '0;
  task automatic acc(input logic [9:0] a, input logic rd, input logic [7:0] d);
    @(negedge clk);
    io_req <= '{a, rd, !rd, d};
    @(negedge clk);
    // Idle lines carry garbage so a stale address never passes for a cycle
    io_req <= '{~a, 1'b0, 1'b0, ~d};
  endtask : acc
endmodule : fdac_host

/* test_floppy_adapter_control.sv */
// Self-checking bench for the diskette adapter control block
`timescale 1ns/10ps
module test_floppy_adapter_control;
  import fdac_pkg::*;
  logic clk, rstn, clk_en, core_irq, core_drq, io_rdata_oe, core_data_rd_stb, core_data_wr_stb;
  logic core_run_n_hold, bus_irq, bus_irq_oe, bus_drq, bus_drq_oe;
  logic [7:0] io_rdata, core_status, core_data_rd, core_data_wdata, lf;
  fdac_io_req_t io_req;
  fdac_drive_t first_drive, second_drive;
  logic [9:0] exp_rd;
  int fails, n_tests, r, a;
  fdac_top i_fdac_top (
    .clk(clk), .rstn(rstn), .clk_en(clk_en), .io_req(io_req), .io_rdata(io_rdata),
    .io_rdata_oe(io_rdata_oe), .core_status(core_status), .core_data_rd(core_data_rd),
    .core_data_rd_stb(core_data_rd_stb), .core_data_wr_stb(core_data_wr_stb),
    .core_data_wdata(core_data_wdata), .core_run_n_hold(core_run_n_hold),
    .core_irq(core_irq), .core_drq(core_drq), .bus_irq(bus_irq), .bus_irq_oe(bus_irq_oe),
    .bus_drq(bus_drq), .bus_drq_oe(bus_drq_oe), .first_drive(first_drive),
    .second_drive(second_drive)
  );
  fdac_host i_fdac_host (.clk(clk), .io_req(io_req));
  always #25 clk = ~clk;
  function automatic logic [7:0] nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : nx
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("FAIL %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic ctl;
    logic [8:0] s;
    logic [8:0] e;
    s = {bus_irq_oe, bus_drq_oe, bus_irq, bus_drq, core_run_n_hold, first_drive, second_drive};
    e = {r[3], r[3], r[3] & core_irq, r[3] & core_drq, r[2], r[4] && r[1:0] == 0, r[4],
      r[5] && r[1:0] == 1, r[5]};
    chk("ctl", s, e);
  endtask : ctl
  task automatic test_done;
    if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  initial begin
    clk = 0;
    rstn = 0;
    clk_en = 1;
    {core_irq, core_drq, core_status, core_data_rd, r} = '0;
    lf = 8'h3b;
    repeat (8) @(negedge clk);
    rstn = 1;
    ctl();
    for (int i = 0; i < 24; i++) begin
      lf = nx(lf);
      {core_irq, core_drq} = lf[7:6];
      core_status = ~lf;
      core_data_rd = lf;
      // A frozen clock enable must swallow the write
      clk_en = i % 6 != 5;
      i_fdac_host.acc(FDAC_ADDR_DRIVE_CONTROL, 1'b0, lf);
      if (clk_en) r = lf & 8'h3f;
      clk_en = 1;
      @(negedge clk);
      ctl();
      a = FDAC_ADDR_DRIVE_CONTROL + i % 4;
      i_fdac_host.acc(a[9:0], 1'b1, ~lf);
      exp_rd = a == FDAC_ADDR_MAIN_STATUS ? {2'b01, core_status} :
        a == FDAC_ADDR_DATA_PORT ? {2'b11, lf} : 10'h000;
      chk("rd", {core_data_rd_stb, io_rdata_oe, io_rdata}, exp_rd);
      i_fdac_host.acc(FDAC_ADDR_DATA_PORT, 1'b0, ~lf);
      chk("wr", {core_data_wr_stb, core_data_wdata}, {1'b1, ~lf});
    end
    rstn = 0;
    r = 0;
    #5 ctl();
    @(negedge clk) rstn = 1;
    // The register must come back clean and then accept a write right away
    @(negedge clk);
    ctl();
    lf = nx(lf);
    i_fdac_host.acc(FDAC_ADDR_DRIVE_CONTROL, 1'b0, lf);
    r = lf & 8'h3f;
    ctl();
    test_done();
  end
  initial begin
    #100000;
    fails++;
    test_done();
  end
endmodule : test_floppy_adapter_control
